// [verilog/conv_ctrl_pkg.sv]
// Behaviour
// - light-load shutdown only in buck mode, input 0.5 V above output, output below 6 V
// - host writes one to enable light-load shutdown, zero disables it entirely
// - output current under about 5 mA counts as light load
// - light load acts only after persisting past the 10, 20 or 30 s delay selected
// - qualified light load moves sequencer to light-load-disabled, output off, idle mode
// - restart after light-load shutdown only by leaving and re-entering active mode
// - writing the 11-bit output-voltage code changes the target while running
// - reference ramps from old to new code at the selected ramp rate
// - with step-down sink enabled, lowering the code turns on a 70 mA load
// - the step-down sink load turns off once output regulates at the lower target
// - overvoltage sink enabled drives output pulldown while any overvoltage lasts
// - three-bit read-only field shows the sequencer state in real time
// - state field reads 000 whenever the converter is outside active mode
// - codes 000 restart, 001 soft start, 010 fault retry wait, 011 light-load disabled
// - switching frequency fixed at factory, default 500 kHz, host cannot change it
// - output below 3 V enters fault retry wait for 3 s, then restart
// - overvoltage stops switching at once; past 100 ms the device enters idle mode
package conv_ctrl_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned LL_DLY10_S = 10;
  localparam int unsigned LL_DLY20_S = 20;
  localparam int unsigned LL_DLY30_S = 30;
  localparam int unsigned FAULT_WAIT_S = 3;
  localparam int unsigned OV_LIMIT_MS = 100;
  localparam int unsigned LL_DLY10_CYC = LL_DLY10_S * CLK_HZ;
  localparam int unsigned LL_DLY20_CYC = LL_DLY20_S * CLK_HZ;
  localparam int unsigned LL_DLY30_CYC = LL_DLY30_S * CLK_HZ;
  localparam int unsigned FAULT_WAIT_CYC = FAULT_WAIT_S * CLK_HZ;
  localparam int unsigned OV_LIMIT_CYC = (OV_LIMIT_MS * (CLK_HZ / 1000));
  localparam int CNT_W = 30;

  // ==========================================================
  // reference ramp, clocks per code step for each ramp-rate code
  localparam logic [7:0] RAMP_STEP0_CYC = 8'h14;
  localparam logic [7:0] RAMP_STEP1_CYC = 8'h28;
  localparam logic [7:0] RAMP_STEP2_CYC = 8'h50;
  localparam logic [7:0] RAMP_STEP3_CYC = 8'hA0;

  // ==========================================================
  // register offsets
  localparam logic [7:0] LIGHT_LOAD_CONFIG_OFS = 8'h0E;
  localparam logic [7:0] VOUT_LOW_OFS = 8'h10;
  localparam logic [7:0] VOUT_HIGH_OFS = 8'h11;
  localparam logic [7:0] POWER_CTRL_OFS = 8'h12;
  localparam logic [7:0] CONVERTER_STATE_STATUS_OFS = 8'h20;

  // ==========================================================
  // field positions
  localparam int LL_ENABLE_BIT = 7;
  localparam int LL_DELAY_LSB = 0;
  localparam int VOUT_HIGH_LSB = 0;
  localparam int RAMP_RATE_LSB = 3;
  localparam int STEPDOWN_SINK_EN_BIT = 5;
  localparam int OV_SINK_EN_BIT = 6;
  localparam int POWER_REQ_BIT = 0;
  localparam int STATE_CODE_LSB = 0;
  localparam int LL_TIMING_BIT = 3;
  localparam int STEPDOWN_SINK_ON_BIT = 4;
  localparam int OV_SINK_ON_BIT = 5;

  // ==========================================================
  // reset values and fixed codes
  localparam logic [10:0] VOUT_CODE_RESET = 11'h200;
  localparam logic POWER_REQ_RESET = 1'b1;
  localparam logic [1:0] FSW_500K_CODE = 2'h2;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

  // ==========================================================
  // types
  // sequencer status codes
  typedef enum logic [2:0] {
    ST_RESTART = 3'b000,
    ST_SOFT_START = 3'b001,
    ST_FAULT_RETRY_WAIT = 3'b010,
    ST_LIGHT_LOAD_DISABLED = 3'b011
  } seq_state_t;

  typedef enum logic [3:0] {
    I_IDLE = 4'b0000,
    I_ADDR = 4'b0001,
    I_ACK_ADDR = 4'b0010,
    I_REG = 4'b0011,
    I_ACK_REG = 4'b0100,
    I_WRITE = 4'b0101,
    I_ACK_WRITE = 4'b0110,
    I_READ = 4'b0111,
    I_READ_ACK = 4'b1000
  } i2c_state_t;

  // comparator levels from the power stage
  typedef struct packed {
    logic buck_mode;
    logic vin_headroom_ok;
    logic vout_below_6v;
    logic iout_light;
    logic vout_below_3v;
    logic vout_ov;
    logic vout_in_reg;
  } sense_t;

  // controls driven to the power stage
  typedef struct packed {
    logic output_enable;
    logic switching_enable;
    logic high_impedance_idle_mode;
    logic stepdown_sink_on;
    logic ov_sink_on;
    logic [10:0] ref_code;
    logic [1:0] fsw_select;
    logic [2:0] state_code;
  } drive_t;

endpackage

// [verilog/light_load_dvs_state_control.sv]
`timescale 1ns/1ps
`default_nettype none
module light_load_dvs_state_control #(
  parameter logic [6:0] DEV_ADDR = conv_ctrl_pkg::DEV_ADDR_DEFAULT,
  parameter int unsigned LL_DLY10_CYC = conv_ctrl_pkg::LL_DLY10_CYC,
  parameter int unsigned LL_DLY20_CYC = conv_ctrl_pkg::LL_DLY20_CYC,
  parameter int unsigned LL_DLY30_CYC = conv_ctrl_pkg::LL_DLY30_CYC,
  parameter int unsigned FAULT_WAIT_CYC = conv_ctrl_pkg::FAULT_WAIT_CYC,
  parameter int unsigned OV_LIMIT_CYC = conv_ctrl_pkg::OV_LIMIT_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // i2c register port, sda open drain
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // enable pin and power stage
  input wire logic EN,
  input wire conv_ctrl_pkg::sense_t SENSE,
  output conv_ctrl_pkg::drive_t DRIVE
);

  // ==========================================================
  // state
  typedef struct packed {
    conv_ctrl_pkg::i2c_state_t i2c;
    logic scl_prev;
    logic sda_prev;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic sda_oe_n;
    logic sda_out;
    logic ll_en;
    logic [1:0] ll_sel;
    logic [10:0] vout_code;
    logic [1:0] ramp_sel;
    logic stepdown_en;
    logic ov_sink_en;
    logic power_req_bit;
    conv_ctrl_pkg::seq_state_t seq;
    logic active;
    logic idle_mode;
    logic [conv_ctrl_pkg::CNT_W-1:0] ll_tmr;
    logic [conv_ctrl_pkg::CNT_W-1:0] fault_tmr;
    logic [conv_ctrl_pkg::CNT_W-1:0] ov_tmr;
    logic [7:0] ramp_cnt;
    conv_ctrl_pkg::drive_t drv;
  } state_t;

  localparam conv_ctrl_pkg::drive_t DRV_RESET = '{
    ref_code: conv_ctrl_pkg::VOUT_CODE_RESET,
    fsw_select: conv_ctrl_pkg::FSW_500K_CODE,
    default: '0
  };

  localparam state_t S_RESET = '{
    i2c: conv_ctrl_pkg::I_IDLE,
    seq: conv_ctrl_pkg::ST_RESTART,
    scl_prev: 1'b1,
    sda_prev: 1'b1,
    sda_oe_n: 1'b1,
    vout_code: conv_ctrl_pkg::VOUT_CODE_RESET,
    power_req_bit: conv_ctrl_pkg::POWER_REQ_RESET,
    drv: DRV_RESET,
    default: '0
  };

  localparam logic [conv_ctrl_pkg::CNT_W-1:0] LL10 = conv_ctrl_pkg::CNT_W'(LL_DLY10_CYC);
  localparam logic [conv_ctrl_pkg::CNT_W-1:0] LL20 = conv_ctrl_pkg::CNT_W'(LL_DLY20_CYC);
  localparam logic [conv_ctrl_pkg::CNT_W-1:0] LL30 = conv_ctrl_pkg::CNT_W'(LL_DLY30_CYC);
  localparam logic [conv_ctrl_pkg::CNT_W-1:0] FWAIT = conv_ctrl_pkg::CNT_W'(FAULT_WAIT_CYC);
  localparam logic [conv_ctrl_pkg::CNT_W-1:0] OVLIM = conv_ctrl_pkg::CNT_W'(OV_LIMIT_CYC);

  state_t q;
  state_t n;

  // ==========================================================
  // next state
  always_comb begin
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic wr;
    logic [7:0] rdata;
    logic power_req;
    logic avail;
    logic [conv_ctrl_pkg::CNT_W-1:0] ll_dly;
    logic [7:0] step_cyc;
    logic lowered;
    start = q.scl_prev & SCL & q.sda_prev & ~SDA_IN;
    stop = q.scl_prev & SCL & ~q.sda_prev & SDA_IN;
    rise = SCL & ~q.scl_prev;
    fall = ~SCL & q.scl_prev;
    wr = 1'b0;
    lowered = 1'b0;
    rdata = 8'h00;
    power_req = 1'b0;
    avail = 1'b0;
    ll_dly = '0;
    step_cyc = 8'h00;
    n = q;
    n.scl_prev = SCL;
    n.sda_prev = SDA_IN;
    n.sda_out = 1'b0;

    // read mux
    case (q.ptr)
      conv_ctrl_pkg::LIGHT_LOAD_CONFIG_OFS: begin
        rdata[conv_ctrl_pkg::LL_ENABLE_BIT] = q.ll_en;
        rdata[conv_ctrl_pkg::LL_DELAY_LSB +: 2] = q.ll_sel;
      end
      conv_ctrl_pkg::VOUT_LOW_OFS: rdata = q.vout_code[7:0];
      conv_ctrl_pkg::VOUT_HIGH_OFS: begin
        rdata[conv_ctrl_pkg::VOUT_HIGH_LSB +: 3] = q.vout_code[10:8];
        rdata[conv_ctrl_pkg::RAMP_RATE_LSB +: 2] = q.ramp_sel;
        rdata[conv_ctrl_pkg::STEPDOWN_SINK_EN_BIT] = q.stepdown_en;
        rdata[conv_ctrl_pkg::OV_SINK_EN_BIT] = q.ov_sink_en;
      end
      conv_ctrl_pkg::POWER_CTRL_OFS: begin
        rdata[conv_ctrl_pkg::POWER_REQ_BIT] = q.power_req_bit;
      end
      conv_ctrl_pkg::CONVERTER_STATE_STATUS_OFS: begin
        rdata[conv_ctrl_pkg::STATE_CODE_LSB +: 3] = q.drv.state_code;
        rdata[conv_ctrl_pkg::LL_TIMING_BIT] = (q.ll_tmr != '0);
        rdata[conv_ctrl_pkg::STEPDOWN_SINK_ON_BIT] = q.drv.stepdown_sink_on;
        rdata[conv_ctrl_pkg::OV_SINK_ON_BIT] = q.drv.ov_sink_on;
      end
      default: ;
    endcase

    // ==========================================================
    // i2c slave; sda changes only while scl is low
    if (start) begin
      n.i2c = conv_ctrl_pkg::I_ADDR;
      n.bit_cnt = 4'h0;
      n.sda_oe_n = 1'b1;
    end else if (stop) begin
      n.i2c = conv_ctrl_pkg::I_IDLE;
      n.sda_oe_n = 1'b1;
    end else if (rise) begin
      case (q.i2c)
        conv_ctrl_pkg::I_ADDR, conv_ctrl_pkg::I_REG, conv_ctrl_pkg::I_WRITE: begin
          n.shreg = {q.shreg[6:0], SDA_IN};
          n.bit_cnt = q.bit_cnt + 4'h1;
        end
        conv_ctrl_pkg::I_READ: n.bit_cnt = q.bit_cnt + 4'h1;
        conv_ctrl_pkg::I_READ_ACK: begin
          if (SDA_IN) begin
            n.i2c = conv_ctrl_pkg::I_IDLE;
          end
        end
        default: ;
      endcase
    end else if (fall) begin
      case (q.i2c)
        conv_ctrl_pkg::I_ADDR: begin
          if (q.bit_cnt == 4'h8) begin
            if (q.shreg[7:1] == DEV_ADDR) begin
              n.sda_oe_n = 1'b0;
              n.rw = q.shreg[0];
              n.i2c = conv_ctrl_pkg::I_ACK_ADDR;
            end else begin
              n.i2c = conv_ctrl_pkg::I_IDLE;
            end
          end
        end
        conv_ctrl_pkg::I_ACK_ADDR, conv_ctrl_pkg::I_READ_ACK: begin
          n.bit_cnt = 4'h0;
          if (q.rw) begin
            n.shreg = rdata;
            n.ptr = q.ptr + 8'h01;
            n.sda_oe_n = rdata[7];
            n.i2c = conv_ctrl_pkg::I_READ;
          end else begin
            n.sda_oe_n = 1'b1;
            n.i2c = conv_ctrl_pkg::I_REG;
          end
        end
        conv_ctrl_pkg::I_REG: begin
          if (q.bit_cnt == 4'h8) begin
            n.ptr = q.shreg;
            n.sda_oe_n = 1'b0;
            n.i2c = conv_ctrl_pkg::I_ACK_REG;
          end
        end
        conv_ctrl_pkg::I_ACK_REG, conv_ctrl_pkg::I_ACK_WRITE: begin
          n.sda_oe_n = 1'b1;
          n.bit_cnt = 4'h0;
          n.i2c = conv_ctrl_pkg::I_WRITE;
        end
        conv_ctrl_pkg::I_WRITE: begin
          if (q.bit_cnt == 4'h8) begin
            wr = 1'b1;
            n.ptr = q.ptr + 8'h01;
            n.sda_oe_n = 1'b0;
            n.i2c = conv_ctrl_pkg::I_ACK_WRITE;
          end
        end
        conv_ctrl_pkg::I_READ: begin
          if (q.bit_cnt == 4'h8) begin
            n.sda_oe_n = 1'b1;
            n.i2c = conv_ctrl_pkg::I_READ_ACK;
          end else begin
            n.shreg = {q.shreg[6:0], 1'b0};
            n.sda_oe_n = q.shreg[6];
          end
        end
        default: n.i2c = conv_ctrl_pkg::I_IDLE;
      endcase
    end

    // ==========================================================
    // register writes; status and unmapped offsets ignore writes
    if (wr) begin
      case (q.ptr)
        conv_ctrl_pkg::LIGHT_LOAD_CONFIG_OFS: begin
          n.ll_en = q.shreg[conv_ctrl_pkg::LL_ENABLE_BIT];
          n.ll_sel = q.shreg[conv_ctrl_pkg::LL_DELAY_LSB +: 2];
        end
        conv_ctrl_pkg::VOUT_LOW_OFS: n.vout_code[7:0] = q.shreg;
        conv_ctrl_pkg::VOUT_HIGH_OFS: begin
          n.vout_code[10:8] = q.shreg[conv_ctrl_pkg::VOUT_HIGH_LSB +: 3];
          n.ramp_sel = q.shreg[conv_ctrl_pkg::RAMP_RATE_LSB +: 2];
          n.stepdown_en = q.shreg[conv_ctrl_pkg::STEPDOWN_SINK_EN_BIT];
          n.ov_sink_en = q.shreg[conv_ctrl_pkg::OV_SINK_EN_BIT];
        end
        conv_ctrl_pkg::POWER_CTRL_OFS: n.power_req_bit = q.shreg[conv_ctrl_pkg::POWER_REQ_BIT];
        default: ;
      endcase
      lowered = (q.ptr == conv_ctrl_pkg::VOUT_LOW_OFS || q.ptr == conv_ctrl_pkg::VOUT_HIGH_OFS)
        && (n.vout_code < q.drv.ref_code);
    end

    // ==========================================================
    // power-on sequencer
    power_req = EN & q.power_req_bit;
    avail = SENSE.buck_mode & SENSE.vin_headroom_ok & SENSE.vout_below_6v;
    case (q.ll_sel)
      2'h0: ll_dly = LL10;
      2'h1: ll_dly = LL20;
      default: ll_dly = LL30;
    endcase
    if (!power_req) begin
      // dropping the request is the only way out of shutdown latches
      n.active = 1'b0;
      n.idle_mode = 1'b0;
      n.seq = conv_ctrl_pkg::ST_RESTART;
      n.ll_tmr = '0;
      n.fault_tmr = '0;
      n.ov_tmr = '0;
    end else if (!q.idle_mode) begin
      n.active = 1'b1;
      case (q.seq)
        conv_ctrl_pkg::ST_RESTART: n.seq = conv_ctrl_pkg::ST_SOFT_START;
        conv_ctrl_pkg::ST_SOFT_START: begin
          if (SENSE.vout_below_3v) begin
            n.seq = conv_ctrl_pkg::ST_FAULT_RETRY_WAIT;
            n.fault_tmr = '0;
            n.ll_tmr = '0;
          end else if (q.ll_en && avail && SENSE.iout_light) begin
            if (q.ll_tmr >= ll_dly) begin
              n.seq = conv_ctrl_pkg::ST_LIGHT_LOAD_DISABLED;
            end else begin
              n.ll_tmr = q.ll_tmr + 1'b1;
            end
          end else begin
            n.ll_tmr = '0;
          end
        end
        conv_ctrl_pkg::ST_FAULT_RETRY_WAIT: begin
          if (q.fault_tmr >= FWAIT - 1'b1) begin
            n.seq = conv_ctrl_pkg::ST_RESTART;
          end else begin
            n.fault_tmr = q.fault_tmr + 1'b1;
          end
        end
        conv_ctrl_pkg::ST_LIGHT_LOAD_DISABLED: n.seq = conv_ctrl_pkg::ST_LIGHT_LOAD_DISABLED;
        default: n.seq = conv_ctrl_pkg::ST_RESTART;
      endcase
      if (SENSE.vout_ov) begin
        if (q.ov_tmr >= OVLIM) begin
          n.idle_mode = 1'b1;
          n.active = 1'b0;
          n.seq = conv_ctrl_pkg::ST_RESTART;
          n.ll_tmr = '0;
        end else begin
          n.ov_tmr = q.ov_tmr + 1'b1;
        end
      end else begin
        n.ov_tmr = '0;
      end
    end

    // ==========================================================
    // reference ramp toward the written code
    case (q.ramp_sel)
      2'h0: step_cyc = conv_ctrl_pkg::RAMP_STEP0_CYC;
      2'h1: step_cyc = conv_ctrl_pkg::RAMP_STEP1_CYC;
      2'h2: step_cyc = conv_ctrl_pkg::RAMP_STEP2_CYC;
      default: step_cyc = conv_ctrl_pkg::RAMP_STEP3_CYC;
    endcase
    // one code step per ramp interval
    if (q.drv.ref_code != q.vout_code) begin
      if (q.ramp_cnt >= step_cyc - 8'h01) begin
        n.ramp_cnt = 8'h00;
        if (q.drv.ref_code < q.vout_code) begin
          n.drv.ref_code = q.drv.ref_code + 11'h001;
        end else begin
          n.drv.ref_code = q.drv.ref_code - 11'h001;
        end
      end else begin
        n.ramp_cnt = q.ramp_cnt + 8'h01;
      end
    end else begin
      n.ramp_cnt = 8'h00;
    end

    // ==========================================================
    // sinks and power stage controls
    // release once settled at the lower target
    if (q.drv.stepdown_sink_on && q.drv.ref_code == q.vout_code && SENSE.vout_in_reg) begin
      n.drv.stepdown_sink_on = 1'b0;
    end
    // a fresh step down wins over the release
    if (lowered && n.stepdown_en) begin
      n.drv.stepdown_sink_on = 1'b1;
    end
    n.drv.ov_sink_on = q.ov_sink_en & SENSE.vout_ov;
    n.drv.output_enable = n.active && n.seq == conv_ctrl_pkg::ST_SOFT_START;
    // switching stops at once on overvoltage
    n.drv.switching_enable = n.drv.output_enable & ~SENSE.vout_ov;
    // light-load state also idles the stage
    n.drv.high_impedance_idle_mode = n.idle_mode
      | (n.active && n.seq == conv_ctrl_pkg::ST_LIGHT_LOAD_DISABLED);
    n.drv.state_code = n.active ? n.seq : conv_ctrl_pkg::ST_RESTART;
    n.drv.fsw_select = conv_ctrl_pkg::FSW_500K_CODE;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      q <= S_RESET;
    end else begin
      q <= n;
    end
  end

  assign SDA_OUT = q.sda_out;
  assign SDA_OE_N = q.sda_oe_n;
  assign DRIVE = q.drv;

endmodule
`default_nettype wire

// [tb/ll_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module ll_ctrl_assertions #(
  parameter int unsigned LL_DLY10_CYC = 40,
  parameter int unsigned FAULT_WAIT_CYC = 30
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // i2c port
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  // enable and power stage
  input wire logic EN,
  input wire conv_ctrl_pkg::sense_t SENSE,
  input wire conv_ctrl_pkg::drive_t DRIVE
);
  int light_cnt;
  int wait_cnt;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  // ==========================================
  // helper counters
  // qualifying light-load cycles seen while running
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      light_cnt <= 0;
      wait_cnt <= 0;
    end else begin
      light_cnt <= (SENSE.iout_light && SENSE.buck_mode && SENSE.vin_headroom_ok &&
        SENSE.vout_below_6v && DRIVE.state_code == 3'h1) ? light_cnt + 1 : 0;
      wait_cnt <= (DRIVE.state_code == 3'h2) ? wait_cnt + 1 : 0;
    end
  end

  // ==========================================
  // properties
  AST_FSW_FIXED: assert property (DRIVE.fsw_select == 2'h2)
    else $error("switching frequency select moved");
  AST_STATE_VALID: assert property (!DRIVE.state_code[2])
    else $error("invalid state code");
  AST_OFF_ZERO: assert property (!EN ##1 !EN |-> DRIVE.state_code == 3'h0)
    else $error("state code not zero while disabled");
  AST_OV_STOP: assert property (SENSE.vout_ov |=> !DRIVE.switching_enable)
    else $error("switching kept on during overvoltage");
  AST_OV_SINK_OFF: assert property (!SENSE.vout_ov |=> !DRIVE.ov_sink_on)
    else $error("overvoltage sink on without overvoltage");
  AST_LL_OFF: assert property (DRIVE.state_code == 3'h3 |->
    !DRIVE.output_enable && DRIVE.high_impedance_idle_mode)
    else $error("light-load state with output on");
  AST_LL_DELAY: assert property (DRIVE.state_code == 3'h3 &&
    $past(DRIVE.state_code) == 3'h1 |-> light_cnt >= LL_DLY10_CYC)
    else $error("light-load shutdown before delay");
  AST_RETRY_ENTRY: assert property (DRIVE.state_code == 3'h1 &&
    SENSE.vout_below_3v && EN ##1 EN |-> DRIVE.state_code == 3'h2)
    else $error("low output did not enter retry wait");
  AST_RETRY_LEN: assert property ($past(DRIVE.state_code) == 3'h2 &&
    DRIVE.state_code == 3'h0 && EN && $past(EN) |-> wait_cnt >= FAULT_WAIT_CYC)
    else $error("retry wait too short");
  AST_RAMP_STEP: assert property ($changed(DRIVE.ref_code) |->
    (DRIVE.ref_code == $past(DRIVE.ref_code) + 11'h001 ||
    DRIVE.ref_code + 11'h001 == $past(DRIVE.ref_code)) ##1 $stable(DRIVE.ref_code)[*8])
    else $error("reference ramp step wrong");
endmodule

bind light_load_dvs_state_control ll_ctrl_assertions #(.LL_DLY10_CYC(LL_DLY10_CYC),
  .FAULT_WAIT_CYC(FAULT_WAIT_CYC)) u_chk (.CLK(CLK), .RST_B(RST_B), .SCL(SCL),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .EN(EN), .SENSE(SENSE),
  .DRIVE(DRIVE));
`default_nettype wire

// [tb/ll_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ll_host_model #(
  parameter logic [6:0] DEV_ADDR = conv_ctrl_pkg::DEV_ADDR_DEFAULT
) (
  // clock
  input wire logic clk,
  // i2c wire
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda
);
  logic drv_q = 1'b1;
  int hold = 4;

  // ==========================================
  // open drain with pull-up: released bus reads high
  assign sda = drv_q & sda_oe_n;
  initial scl = 1'b1;

  // ==========================================
  // bit level, scl phases stretched by hold
  task automatic half();
    repeat (hold) @(negedge clk);
  endtask
  task automatic put(input logic b);
    drv_q = b;
    half();
    scl = 1'b1;
    half();
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic get(output logic b);
    drv_q = 1'b1;
    half();
    scl = 1'b1;
    half();
    b = sda;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic start();
    drv_q = 1'b1;
    half();
    scl = 1'b1;
    half();
    drv_q = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    drv_q = 1'b0;
    half();
    scl = 1'b1;
    half();
    drv_q = 1'b1;
    half();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    ack = !a;
  endtask

  // ==========================================
  // register transfers
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    send({DEV_ADDR, 1'b0}, a0);
    send(ofs, a1);
    send(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    send({DEV_ADDR, 1'b0}, a0);
    send(ofs, a1);
    start();
    send({DEV_ADDR, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// [tb/light_load_dvs_state_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
module light_load_dvs_state_control_test;
  localparam int D10 = 40;
  localparam int D20 = 80;
  localparam int D30 = 120;
  localparam int FW = 30;
  localparam int OVL = 20;
  logic clk, rst_b, en, scl, sda, sda_out, sda_oe_n, ok;
  conv_ctrl_pkg::sense_t sense;
  conv_ctrl_pkg::drive_t drive;
  int error_cnt, checked, n, dly, step;
  logic [31:0] rng;
  logic [7:0] rdat;
  logic [1:0] rr;

  light_load_dvs_state_control #(.LL_DLY10_CYC(D10), .LL_DLY20_CYC(D20),
    .LL_DLY30_CYC(D30), .FAULT_WAIT_CYC(FW), .OV_LIMIT_CYC(OVL)) u_dut (.CLK(clk),
    .RST_B(rst_b), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
    .EN(en), .SENSE(sense), .DRIVE(drive));
  ll_host_model u_host (.clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    u_host.wr(ofs, d, ok);
    chk("write ack", 1, ok);
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp, input logic [7:0] m);
    u_host.rd(ofs, rdat, ok);
    chk("read ack", 1, ok);
    chk("read data", exp, rdat & m);
  endtask
  task automatic wait_st(input logic [2:0] v, input int lim);
    n = 0;
    while (drive.state_code !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk("state", v, drive.state_code);
  endtask
  task automatic wait_chg();
    logic [10:0] r0;
    r0 = drive.ref_code;
    n = 0;
    while (drive.ref_code === r0 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================
  // watchdog: tests need about 23k cycles
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  // ==========================================
  // main sequence; sense 71 = buck, headroom, below 6 V, in regulation
  initial begin
    error_cnt = 0;
    checked = 0;
    rng = 32'hE33F;
    rst_b = 1'b0;
    en = 1'b1;
    sense = 7'h71;
    cyc(12);
    rst_b = 1'b1;
    wait_st(3'h1, 10);
    chk("fsw", 2'h2, drive.fsw_select);
    rd(8'h0E, 8'h00, 8'hFF);
    wr(8'h20, 8'h03);
    rd(8'h20, 8'h01, 8'hFF);
    rd(8'h3C, 8'h00, 8'hFF);
    // one availability condition off each pass, last pass feature off
    for (int k = 0; k < 4; k++) begin
      wr(8'h0E, k == 3 ? 8'h01 : 8'h81);
      sense = (7'h71 ^ (k == 3 ? 7'h00 : 7'h40 >> k)) | 7'h08;
      cyc(D30 + 20);
      chk("state", 3'h1, drive.state_code);
      sense = 7'h71;
      cyc(1);
    end
    for (int c = 0; c < 4; c++) begin
      rng = xs(rng);
      u_host.hold = 4 + int'(rng[1:0]);
      dly = c == 0 ? D10 : c == 1 ? D20 : D30;
      wr(8'h0E, 8'h80 | c[7:0]);
      rd(8'h0E, 8'h80 | c[7:0], 8'hFF);
      // a gap just before expiry must restart the count
      sense = 7'h79;
      cyc(dly - 3);
      sense = 7'h71;
      cyc(1);
      sense = 7'h79;
      wait_st(3'h3, dly + 10);
      chk("light delay", dly + 1, n);
      chk("off idle", 2'h1, {drive.output_enable, drive.high_impedance_idle_mode});
      sense = 7'h71;
      rd(8'h20, 8'h03, 8'h07);
      chk("state", 3'h3, drive.state_code);
      if (c[0]) wr(8'h12, 8'h00);
      else en = 1'b0;
      cyc(3);
      chk("state", 3'h0, drive.state_code);
      if (c[0]) wr(8'h12, 8'h01);
      else en = 1'b1;
      wait_st(3'h1, 10);
    end
    sense = 7'h75;
    cyc(1);
    sense = 7'h71;
    wait_st(3'h2, 5);
    wait_st(3'h0, FW + 5);
    chk("retry wait", FW, n);
    wait_st(3'h1, 5);
    chk("run", 4'hC, {drive.output_enable, drive.switching_enable,
      drive.high_impedance_idle_mode, sda_out});
    rng = xs(rng);
    rr = rng[1:0];
    step = 20 << rr;
    wr(8'h11, {3'h1, rr, 3'h2});
    wr(8'h10, 8'h08);
    wait_chg();
    wait_chg();
    chk("ramp step", step, n);
    cyc(8 * step + 5);
    chk("ref up", 11'h208, drive.ref_code);
    chk("sink", 0, drive.stepdown_sink_on);
    sense = 7'h70;
    wr(8'h10, 8'h00);
    chk("sink", 1, drive.stepdown_sink_on);
    cyc(8 * step + 5);
    chk("ref down", 11'h200, drive.ref_code);
    chk("sink", 1, drive.stepdown_sink_on);
    sense = 7'h71;
    cyc(2);
    chk("sink", 0, drive.stepdown_sink_on);
    wr(8'h11, 8'h42);
    sense = 7'h73;
    cyc(2);
    chk("ov", 3'h2, {drive.switching_enable, drive.ov_sink_on, drive.high_impedance_idle_mode});
    cyc(OVL + 5);
    chk("ov idle", 4'h6, {drive.switching_enable, drive.ov_sink_on,
      drive.high_impedance_idle_mode, drive.state_code != 3'h0});
    sense = 7'h71;
    cyc(2);
    chk("ov sink", 0, drive.ov_sink_on);
    en = 1'b0;
    cyc(2);
    en = 1'b1;
    wait_st(3'h1, 10);
    print_verdict();
  end
endmodule
`default_nettype wire
